// ==== core/kse_encoder.v ====
// Keyboard matrix scan encoder top level with Avalon-MM register slave.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`include "kse_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module kse_encoder #(
	parameter SCAN_DIV = `KSE_SCAN_DIV,
	parameter DEB_SCANS = `KSE_DEB_SCANS
) (
	// Clock and reset.
	input wire ref_clk,
	input wire rst,
	// Matrix: drive lines out, sense lines in, high when a key closes.
	output reg [8:0] drive,
	input wire [9:0] sense,
	// Mode and rollover select pins.
	input wire shift_key,
	input wire ctrl_key,
	input wire rollover_sel,
	// Parallel outputs.
	output reg [10:1] key_code,
	output reg data_ready,
	output reg any_key_down,
	// Avalon-MM slave.
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest
);
	localparam ST_DRIVE = 4'b0001;
	localparam ST_READ = 4'b0010;
	localparam ST_UPDATE = 4'b0100;
	localparam ST_IDLE = 4'b1000;

	reg [3:0] state;
	reg [17:0] osc_cnt;
	reg scan_tick;
	reg [3:0] drv_idx;
	reg [3:0] sen_idx;
	reg [6:0] key_idx;
	reg [9:0] sense_cap;
	reg [6:0] held_cnt;
	reg [6:0] held_this;
	reg roll_ctrl;
	reg [31:0] next_readdata;
	reg [3:0] next_word;
	reg mem_we;
	reg new_press;
	wire [9:0] sense_s;
	wire [2:0] pins_s;
	wire [3:0] mem_rd;
	wire roll_mode;
	wire mode_shift;
	wire mode_ctrl;
	wire closed;

	// Pins from outside pass two flip-flops before use.
	kse_sync #(.WIDTH(10)) u_sync_sense (
		.ref_clk(ref_clk),
		.rst(rst),
		.din(sense),
		.dout(sense_s)
	);
	kse_sync #(.WIDTH(3)) u_sync_pins (
		.ref_clk(ref_clk),
		.rst(rst),
		.din({rollover_sel, ctrl_key, shift_key}),
		.dout(pins_s)
	);
	assign mode_shift = pins_s[0];
	assign mode_ctrl = pins_s[1];
	assign roll_mode = pins_s[2] | roll_ctrl;
	assign closed = sense_cap[sen_idx];

	// Word layout: bit 3 stable, bits 2..0 debounce count.
	kse_key_mem #(.DEPTH(`KSE_KEYS), .AW(7), .DW(4)) u_mem (
		.ref_clk(ref_clk),
		.wr_en(mem_we),
		.wr_addr(key_idx),
		.wr_data(next_word),
		.rd_addr(key_idx),
		.rd_data(mem_rd)
	);

	// Internal scan oscillator divides the system clock to the scan rate.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			osc_cnt <= 18'h00000;
			scan_tick <= 1'b0;
		end
		else if (osc_cnt == SCAN_DIV[17:0] - 18'h00001)
		begin
			osc_cnt <= 18'h00000;
			scan_tick <= 1'b1;
		end
		else
		begin
			osc_cnt <= osc_cnt + 18'h00001;
			scan_tick <= 1'b0;
		end
	end

	// Debounce: count up while closed up to the threshold, reset when open.
	always @*
	begin
		next_word = mem_rd;
		new_press = 1'b0;
		if (!closed)
			next_word = 4'h0;
		else if (mem_rd[2:0] != DEB_SCANS[2:0])
			next_word = {1'b0, mem_rd[2:0] + 3'h1};
		else
		begin
			next_word = {1'b1, mem_rd[2:0]};
			new_press = ~mem_rd[3];
		end
		mem_we = (state == ST_UPDATE);
	end

	// Scan sequencer walks keys in order, sense index fastest.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			drv_idx <= 4'h0;
			sen_idx <= 4'h0;
			key_idx <= 7'h00;
			drive <= 9'h000;
			sense_cap <= 10'h000;
			held_cnt <= 7'h00;
			held_this <= 7'h00;
			key_code <= 10'h000;
			data_ready <= 1'b0;
			any_key_down <= 1'b0;
		end
		else
		begin
			case (state)
			ST_IDLE:
			begin
				if (scan_tick)
				begin
					drive <= 9'h001 << drv_idx;
					state <= ST_DRIVE;
				end
			end
			ST_DRIVE:
			begin
				// Sense lines settle through the synchroniser before capture.
				if (scan_tick)
				begin
					sense_cap <= sense_s;
					state <= ST_READ;
				end
			end
			ST_READ:
				state <= ST_UPDATE;
			ST_UPDATE:
			begin
				if (next_word[3])
					held_this <= held_this + 7'h01;
				// Lockout accepts a new key only if at most one other key was held at the last full scan.
				if (new_press && (roll_mode || held_cnt <= 7'h01))
				begin
					key_code[9] <= key_idx[0];
					key_code[8] <= key_idx[1];
					key_code[7] <= key_idx[2];
					key_code[6] <= key_idx[3];
					key_code[5] <= key_idx[4];
					key_code[4] <= key_idx[5];
					key_code[1] <= key_idx[6];
					key_code[3] <= mode_shift;
					key_code[2] <= mode_ctrl;
					key_code[10] <= 1'b0;
					data_ready <= 1'b1;
				end
				if (sen_idx == `KSE_SENSES - 1)
				begin
					sen_idx <= 4'h0;
					drive <= 9'h000;
					if (drv_idx == `KSE_DRIVES - 1)
					begin
						drv_idx <= 4'h0;
						key_idx <= 7'h00;
						held_cnt <= held_this + {6'h00, next_word[3]};
						any_key_down <= (held_this + {6'h00, next_word[3]}) != 7'h00;
						held_this <= 7'h00;
					end
					else
					begin
						drv_idx <= drv_idx + 4'h1;
						key_idx <= key_idx + 7'h01;
					end
					state <= ST_IDLE;
				end
				else
				begin
					sen_idx <= sen_idx + 4'h1;
					key_idx <= key_idx + 7'h01;
					state <= ST_READ;
				end
			end
			default:
				state <= ST_IDLE;
			endcase
			if (avs_write && !avs_waitrequest && avs_address == `KSE_REG_CTRL
				&& avs_writedata[`KSE_CTRL_CLEAR])
				data_ready <= 1'b0;
			if (avs_read && !avs_waitrequest && avs_address == `KSE_REG_CODE)
				data_ready <= 1'b0;
			if (state == ST_UPDATE && new_press && (roll_mode || held_cnt <= 7'h01))
				data_ready <= 1'b1;
		end
	end

	// Read data decode; an unmapped address answers a fixed pattern.
	always @*
	begin
		if (avs_address == `KSE_REG_CODE)
			next_readdata = {22'h000000, key_code};
		else if (avs_address == `KSE_REG_STAT)
			next_readdata = {30'h00000000, any_key_down, data_ready};
		else if (avs_address == `KSE_REG_CTRL)
			next_readdata = {31'h00000000, roll_ctrl};
		else
			next_readdata = `KSE_UNMAPPED;
	end

	// Each access waits one cycle, then completes with waitrequest low.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			roll_ctrl <= 1'b0;
		end
		else
		begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= next_readdata;
			if (avs_write && !avs_waitrequest && avs_address == `KSE_REG_CTRL)
				roll_ctrl <= avs_writedata[`KSE_CTRL_ROLL];
		end
	end
endmodule // kse_encoder
`default_nettype wire

// ==== core/kse_consts.vh ====
// Constants shared by the keyboard matrix scan encoder design files.
// How it works
// - Key codes count in scan order from drive 0 sense 0, sense fastest.
// - Key count appears on code bits 9,8,7,6,5,4,1; bit 9 least significant.
// - Bits 2 and 3 give the mode; bit 3 is high for shift modes.
// - Closures are debounced; an unstable closure never yields a key code.
// - A select input chooses N-key lockout or N-key rollover.
// - An internal scan oscillator steps the matrix; no external scan clock needed.
// - An any-key-down output is high while at least one key is held.
`ifndef KSE_CONSTS_VH
`define KSE_CONSTS_VH
`define KSE_CLK_MHZ 250
`define KSE_SCAN_KHZ 50
`define KSE_SCAN_DIV ((`KSE_CLK_MHZ * 1000) / `KSE_SCAN_KHZ)
`define KSE_DRIVES 9
`define KSE_SENSES 10
`define KSE_KEYS 90
`define KSE_DEB_SCANS 4
`define KSE_REG_CODE 4'h0
`define KSE_REG_STAT 4'h4
`define KSE_REG_CTRL 4'h8
`define KSE_STAT_READY 0
`define KSE_STAT_ANY 1
`define KSE_CTRL_ROLL 0
`define KSE_CTRL_CLEAR 1
`define KSE_UNMAPPED 32'hdeadbeef
`endif

// ==== core/kse_sync.v ====
// Two flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
module kse_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset.
	input wire ref_clk,
	input wire rst,
	// Data.
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			meta <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // kse_sync
`default_nettype wire

// ==== core/kse_key_mem.v ====
// Per-key debounce counters and stable state, one memory word per key.
`timescale 1ns/1ns
`default_nettype none
module kse_key_mem #(
	parameter DEPTH = 90,
	parameter AW = 7,
	parameter DW = 4
) (
	// Clock.
	input wire ref_clk,
	// Write port.
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// Registered read port.
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:DEPTH-1];
	integer i;

	// Memory is cleared at start so simulation begins with all keys released.
	initial
	begin
		for (i = 0; i < DEPTH; i = i + 1)
			mem[i] = {DW{1'b0}};
	end

	// Read data come out of a register, one cycle after the address.
	always @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule // kse_key_mem
`default_nettype wire

// ==== dv/kse_matrix_model.sv ====
// Keyswitch matrix model with one isolating diode per switch.
`timescale 1ns/1ns
`default_nettype none
module kse_matrix_model (
	// Drive lines from the encoder.
	input wire logic [8:0] drive,
	// Keys held, index is drive times ten plus sense.
	input wire logic [89:0] keys,
	// Sense lines back to the encoder.
	output logic [9:0] sense
);
	// Sense lines sit at the pull-down level unless a closed key meets a driven line.
	always_comb
	begin
		sense = 10'h000;
		for (int i = 0; i < 9; i++)
			for (int j = 0; j < 10; j++)
				if (drive[i] && keys[i * 10 + j])
					sense[j] = 1'b1;
	end
endmodule // kse_matrix_model
`default_nettype wire

// ==== dv/kse_encoder_props.sv ====
// Concurrent checks on the encoder's ports.
`timescale 1ns/1ns
`default_nettype none
module kse_encoder_props #(
	parameter SCAN_DIV = 8,
	parameter DEB_SCANS = 4
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Matrix and key outputs.
	input wire logic [8:0] drive,
	input wire logic [9:0] sense,
	input wire logic [10:1] key_code,
	input wire logic data_ready,
	input wire logic any_key_down,
	// Register bus.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	logic [8:0] last_drv;
	logic [9:0] quiet;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Last line driven and a count of quiet sense cycles, so order and idle can be judged.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			last_drv <= 9'h000;
		else if (drive != 9'h000)
			last_drv <= drive;
		if (rst || sense != 10'h000)
			quiet <= 10'h000;
		else if (quiet != 10'h3ff)
			quiet <= quiet + 10'h001;
	end
	AST_BIT10: assert property (key_code[10] == 1'b0) else $error("spare code bit set");
	AST_DRV_ONEHOT: assert property ($onehot0(drive)) else $error("two lines driven");
	AST_DRV_ORDER: assert property (drive != 9'h000 && last_drv != 9'h000 && drive != last_drv
		|-> drive == (last_drv[8] ? 9'h001 : last_drv << 1)) else $error("scan out of order");
	AST_SCAN_RUNS: assert property (1'b1 |-> ##[0:40] drive != 9'h000) else $error("scan stalled");
	AST_QUIET_IDLE: assert property (quiet == 10'h3ff |-> !any_key_down) else $error("stuck key");
	AST_QUIET_NOCODE: assert property (quiet == 10'h3ff |-> !$rose(data_ready))
		else $error("code without closure");
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	AST_WAIT_BACK: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait not back");
	AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address == 4'hc
		|-> avs_readdata == 32'hdeadbeef) else $error("unmapped read value");
	COV_KEY: cover property ($rose(data_ready));
	COV_ANY: cover property ($fell(any_key_down));
	COV_RD: cover property (avs_read && !avs_waitrequest);
endmodule // kse_encoder_props
bind kse_encoder kse_encoder_props #(.SCAN_DIV(SCAN_DIV), .DEB_SCANS(DEB_SCANS)) u_props (.*);
`default_nettype wire

// ==== dv/kse_encoder_tb_top.sv ====
// Self-checking bench for the keyboard matrix scan encoder.
`timescale 1ns/1ns
`default_nettype none
module kse_encoder_tb_top;
	logic ref_clk, rst, shift_key, ctrl_key, rollover_sel, data_ready, any_key_down, dr_q;
	logic avs_read, avs_write, avs_waitrequest;
	logic [8:0] drive;
	logic [9:0] sense;
	logic [10:1] key_code;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [89:0] keys;
	logic [31:0] expq[$];
	int n_errors, cmp_count, k;
	// Small scan divider keeps a full debounce near fifteen hundred cycles; a real board keeps the
	// default divider so the scan rate stays inside its allowed band.
	kse_encoder #(.SCAN_DIV(8), .DEB_SCANS(4)) DUT (.ref_clk(ref_clk), .rst(rst), .drive(drive),
		.sense(sense), .shift_key(shift_key), .ctrl_key(ctrl_key), .rollover_sel(rollover_sel),
		.key_code(key_code), .data_ready(data_ready), .any_key_down(any_key_down),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	kse_matrix_model u_mat (.drive(drive), .keys(keys), .sense(sense));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// Position count spread over bits 9..4 and 1, mode on bits 3 and 2.
	function automatic logic [31:0] ec(input int k, input logic [1:0] m);
		logic [6:0] b;
		b = k[6:0];
		return {22'h0, 1'b0, b[0], b[1], b[2], b[3], b[4], b[5], m[0], m[1], b[6]};
	endfunction
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, d};
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		{avs_read, avs_write} <= 2'b00;
	endtask
	task automatic press(input int k, input logic [1:0] m, input logic exp);
		int i;
		@(posedge ref_clk);
		{ctrl_key, shift_key} <= m;
		keys[k] <= 1'b1;
		if (exp)
			expq.push_back(ec(k, m));
		for (i = 0; i < 3000 && data_ready !== 1'b1; i++) @(posedge ref_clk);
		chk("accepted", exp, i < 3000);
		// Any-key-down only moves at the end of a full scan, so let that scan finish first.
		for (i = 0; i < 700 && any_key_down !== 1'b1; i++) @(posedge ref_clk);
		bus(0, 4'h4, 0);
		chk("status", {30'h0, 1'b1, exp}, q);
		bus(0, 4'h0, 0);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Clock at 250 MHz.
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Each new code is matched against the oldest expectation; an unexpected one is flagged.
	always @(posedge ref_clk)
	begin
		if (!rst && data_ready === 1'b1 && dr_q !== 1'b1)
			chk("key_code", expq.size() ? expq.pop_front() : 32'hffffffff, {22'h0, key_code});
		dr_q <= data_ready;
	end
	// Watchdog against a hung wait.
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		n_errors++;
		finish_test();
	end
	// Main sequence: codes in all modes, bounce, rollover and lockout, unmapped read.
	initial
	begin
		{rst, keys, shift_key, ctrl_key, rollover_sel, avs_read, avs_write} = {1'b1, 96'h0};
		{avs_address, avs_writedata, dr_q} = 37'h0;
		void'($urandom(32'h23f14d1e));
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		for (int n = 0; n < 8; n++)
		begin
			k = n == 0 ? 0 : n == 1 ? 89 : $urandom % 90;
			press(k, n[1:0], 1'b1);
			keys <= 90'h0;
			repeat (700) @(posedge ref_clk);
			chk("any_key_down", 0, any_key_down);
		end
		// Closures shorter than a scan must never give a code.
		repeat (40)
		begin
			@(posedge ref_clk);
			keys[$urandom % 90] <= 1'b1;
			repeat ($urandom % 60) @(posedge ref_clk);
			keys <= 90'h0;
		end
		repeat (1000) @(posedge ref_clk);
		for (int s = 0; s < 2; s++)
		begin
			rollover_sel <= s[0];
			press(10, 2'b00, 1'b1);
			press(20, 2'b00, 1'b1);
			press(30, 2'b00, s[0]);
			keys <= 90'h0;
			repeat (700) @(posedge ref_clk);
		end
		// The forced rollover bit must read back as written.
		bus(1, 4'h8, 32'h1);
		bus(0, 4'h8, 0);
		chk("ctrl", 32'h1, q);
		bus(0, 4'hc, 0);
		chk("unmapped", 32'hdeadbeef, q);
		finish_test();
	end
endmodule // kse_encoder_tb_top
`default_nettype wire
